// File: boot_loader_pkg.sv
// Constants shared by the serial memory boot loader
package boot_loader_pkg;
   localparam logic [7:0] READ_OPCODE = 8'h03;
   localparam logic [7:0] START_ADDR = 8'h00;
   localparam logic [7:0] OP_WRITE_MASK = 8'h80;
   localparam logic [7:0] OP_CTRL_WRITE = 8'h78;
   localparam logic [7:0] OP_MODES_WRITE = 8'h60;
   localparam logic [7:0] OP_MASK_WRITE = 8'h74;
   localparam logic [7:0] OP_CONTINUOUS = 8'he8;
   localparam logic [23:0] CTRL_STOP_BIT = 24'h000100;
   localparam int CLK_HZ = 10000000;
   localparam int SCLK_HZ = 500000;
   localparam int HALF_PERIOD = CLK_HZ / (2 * SCLK_HZ);
   localparam logic [3:0] HALF_CYCLES = 4'(HALF_PERIOD);
   localparam logic [2:0] BYTE_LAST_BIT = 3'h7;
   localparam logic [1:0] DATA_BYTES = 2'h3;
   localparam int CMD_ONLY_POS = 7;
   localparam int LSD_BIT_POS = 2;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_INIT = 3'b001,
      ST_CMD = 3'b010,
      ST_ADDR = 3'b011,
      ST_FETCH = 3'b100,
      ST_EXEC = 3'b101,
      ST_DONE = 3'b110
   } state_t;
endpackage : boot_loader_pkg

// File: sclk_divider.sv
// Serial clock half-period enable divider
`timescale 1ns/1ns
module sclk_divider (
   input wire logic clk,
   input wire logic rst,
   input wire logic run,
   output logic tick
);
   logic [3:0] count;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         count <= 4'h0;
         tick <= 1'b0;
      end else if (!run) begin
         count <= 4'h0;
         tick <= 1'b0;
      end else if (count == boot_loader_pkg::HALF_CYCLES - 4'h1) begin
         count <= 4'h0;
         tick <= 1'b1;
      end else begin
         count <= count + 4'h1;
         tick <= 1'b0;
      end
   end
endmodule : sclk_divider

// File: serial_eeprom_boot_loader.sv
// Boot loader that fetches and executes commands from a serial memory
`timescale 1ns/1ns
module serial_eeprom_boot_loader (
   input wire logic clk,
   input wire logic rst,
   input wire logic mode_strap,
   input wire logic init_done,
   input wire logic sdi,
   output logic cs_n,
   output logic cs_oe,
   output logic sclk,
   output logic sclk_oe,
   output logic sdo,
   output logic cmd_valid,
   output logic [7:0] cmd_opcode,
   output logic [23:0] cmd_data,
   output logic cmd_has_data,
   output logic modes_write,
   output logic mask_write,
   output logic low_supply_detect_mask_bit,
   output logic conv_start,
   output logic busy,
   output logic done
);
   boot_loader_pkg::state_t state;
   logic strap;
   logic tick;
   logic [2:0] sdi_sync;
   logic [2:0] strap_sync;
   logic sdi_level;
   logic [7:0] shift_out;
   logic [7:0] shift_in;
   logic [2:0] bit_idx;
   logic [1:0] data_left;
   logic [7:0] opcode;
   logic [23:0] data;
   logic sampled;

   // ***************************************
   // Opcode decoding for the parser and level settling for the synchronisers
   // ***************************************
   function automatic logic takes_data(input logic [7:0] op);
      takes_data = !op[boot_loader_pkg::CMD_ONLY_POS];
   endfunction : takes_data

   // A pin level counts only once the second and third stages agree
   function automatic logic settled(input logic [2:0] sync);
      settled = sync[1] == sync[2];
   endfunction : settled

   sclk_divider u_div (
      .clk(clk),
      .rst(rst),
      .run(state == boot_loader_pkg::ST_CMD || state == boot_loader_pkg::ST_ADDR
         || state == boot_loader_pkg::ST_FETCH),
      .tick(tick)
   );

   // ***************************************
   // Strap capture and input synchroniser
   // ***************************************
   // Strap chain has no reset, so it is full when reset ends; a reset value would pose as a strap level
   always_ff @(posedge clk) begin
      strap_sync <= {strap_sync[1:0], mode_strap};
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sdi_sync <= 3'h0;
         sdi_level <= 1'b0;
      end else begin
         sdi_sync <= {sdi_sync[1:0], sdi};
         if (settled(sdi_sync)) begin
            sdi_level <= sdi_sync[2];
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         strap <= 1'b0;
      end else if (state == boot_loader_pkg::ST_IDLE && settled(strap_sync)) begin
         strap <= strap_sync[2];
      end
   end

   // ***************************************
   // Sequencer
   // ***************************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state <= boot_loader_pkg::ST_IDLE;
         cs_n <= 1'b1;
         cs_oe <= 1'b0;
         sclk <= 1'b0;
         sclk_oe <= 1'b0;
         sdo <= 1'b0;
         shift_out <= 8'h00;
         shift_in <= 8'h00;
         bit_idx <= 3'h0;
         data_left <= 2'h0;
         opcode <= 8'h00;
         data <= 24'h000000;
         sampled <= 1'b0;
         busy <= 1'b0;
         done <= 1'b0;
      end else begin
         unique case (state)
            boot_loader_pkg::ST_IDLE: begin
               if (settled(strap_sync)) begin
                  state <= boot_loader_pkg::ST_INIT;
               end
            end
            boot_loader_pkg::ST_INIT: begin
               cs_oe <= strap;
               sclk_oe <= strap;
               if (!strap) begin
                  state <= boot_loader_pkg::ST_DONE;
               end else if (init_done) begin
                  state <= boot_loader_pkg::ST_CMD;
                  cs_n <= 1'b0;
                  busy <= 1'b1;
                  // Only the read opcode is ever loaded, so no write can reach the memory
                  shift_out <= {boot_loader_pkg::READ_OPCODE[6:0], 1'b0};
                  sdo <= boot_loader_pkg::READ_OPCODE[7];
                  bit_idx <= 3'h0;
               end
            end
            boot_loader_pkg::ST_CMD, boot_loader_pkg::ST_ADDR, boot_loader_pkg::ST_FETCH: begin
               if (tick) begin
                  sclk <= !sclk;
                  if (!sclk) begin
                     shift_in <= {shift_in[6:0], sdi_level};
                  end else begin
                     sdo <= shift_out[7];
                     shift_out <= {shift_out[6:0], 1'b0};
                     bit_idx <= bit_idx + 3'h1;
                     if (bit_idx == boot_loader_pkg::BYTE_LAST_BIT) begin
                        if (state == boot_loader_pkg::ST_CMD) begin
                           state <= boot_loader_pkg::ST_ADDR;
                           sdo <= boot_loader_pkg::START_ADDR[7];
                           shift_out <= {boot_loader_pkg::START_ADDR[6:0], 1'b0};
                        end else if (state == boot_loader_pkg::ST_ADDR) begin
                           state <= boot_loader_pkg::ST_FETCH;
                           sdo <= 1'b0;
                           data_left <= 2'h0;
                        end else begin
                           sampled <= 1'b1;
                        end
                     end
                  end
               end
               if (sampled) begin
                  sampled <= 1'b0;
                  if (data_left == 2'h0) begin
                     opcode <= shift_in;
                     if (takes_data(shift_in)) begin
                        data_left <= boot_loader_pkg::DATA_BYTES;
                     end else begin
                        state <= boot_loader_pkg::ST_EXEC;
                     end
                  end else begin
                     data <= {data[15:0], shift_in};
                     data_left <= data_left - 2'h1;
                     if (data_left == 2'h1) begin
                        state <= boot_loader_pkg::ST_EXEC;
                     end
                  end
               end
            end
            boot_loader_pkg::ST_EXEC: begin
               // Clock is parked low between entries so the memory sees no extra edge
               if (opcode == boot_loader_pkg::OP_CTRL_WRITE && (data & boot_loader_pkg::CTRL_STOP_BIT) != 24'h0) begin
                  state <= boot_loader_pkg::ST_DONE;
                  cs_n <= 1'b1;
                  busy <= 1'b0;
               end else begin
                  state <= boot_loader_pkg::ST_FETCH;
                  data_left <= 2'h0;
               end
            end
            boot_loader_pkg::ST_DONE: begin
               cs_n <= 1'b1;
               sclk <= 1'b0;
               busy <= 1'b0;
               done <= 1'b1;
            end
            default: begin
               state <= boot_loader_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // ***************************************
   // Command execution strobes
   // ***************************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cmd_valid <= 1'b0;
         cmd_opcode <= 8'h00;
         cmd_data <= 24'h000000;
         cmd_has_data <= 1'b0;
         modes_write <= 1'b0;
         mask_write <= 1'b0;
         conv_start <= 1'b0;
         low_supply_detect_mask_bit <= 1'b0;
      end else begin
         cmd_valid <= state == boot_loader_pkg::ST_EXEC;
         modes_write <= state == boot_loader_pkg::ST_EXEC && opcode == boot_loader_pkg::OP_MODES_WRITE;
         mask_write <= state == boot_loader_pkg::ST_EXEC && opcode == boot_loader_pkg::OP_MASK_WRITE;
         conv_start <= state == boot_loader_pkg::ST_EXEC && opcode == boot_loader_pkg::OP_CONTINUOUS;
         if (state == boot_loader_pkg::ST_EXEC) begin
            cmd_opcode <= opcode;
            cmd_data <= takes_data(opcode) ? data : 24'h000000;
            cmd_has_data <= takes_data(opcode);
            if (opcode == boot_loader_pkg::OP_MASK_WRITE) begin
               low_supply_detect_mask_bit <= data[boot_loader_pkg::LSD_BIT_POS];
            end
         end
      end
   end
endmodule : serial_eeprom_boot_loader

// File: boot_loader_props.sv
// Checker for the serial memory boot loader
`timescale 1ns/1ns
module boot_loader_props (
   input wire logic clk,
   input wire logic rst,
   input wire logic mode_strap,
   input wire logic init_done,
   input wire logic cs_n,
   input wire logic cs_oe,
   input wire logic sclk,
   input wire logic sclk_oe,
   input wire logic sdo,
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_opcode,
   input wire logic [23:0] cmd_data,
   input wire logic cmd_has_data,
   input wire logic modes_write,
   input wire logic mask_write,
   input wire logic low_supply_detect_mask_bit,
   input wire logic conv_start,
   input wire logic busy,
   input wire logic done
);
   // ****
   // Properties
   // ****
   default clocking dc @(posedge clk);
   endclocking
   default disable iff (rst);
   a_select_drives_pins: assert property (!cs_n |-> cs_oe && sclk_oe && busy)
      else $error("select low without driven pins");
   a_fetch_after_init: assert property ($fell(cs_n) |-> init_done && mode_strap)
      else $error("fetch began too early");
   a_clock_idle_low: assert property (cs_n |-> !sclk)
      else $error("serial clock runs while deselected");
   a_sdo_steady_rise: assert property ($rose(sclk) |-> $stable(sdo))
      else $error("data moved at rising clock");
   a_stop_releases: assert property (cmd_valid && cmd_opcode == 8'h78 && cmd_data[8] |-> ##[1:3] cs_n && done && !busy)
      else $error("stop did not release memory");
   a_entry_length: assert property (cmd_valid |-> cmd_has_data == !cmd_opcode[7])
      else $error("entry length wrong");
   a_conv_single_byte: assert property (conv_start |-> cmd_valid && cmd_opcode == 8'he8 && cmd_data == 24'h000000)
      else $error("bad conversion start");
   a_modes_pulse: assert property (cmd_valid |-> modes_write == (cmd_opcode == 8'h60))
      else $error("modes pulse wrong");
   a_mask_bit_follows: assert property (mask_write |=> low_supply_detect_mask_bit == $past(cmd_data[2]))
      else $error("mask bit not taken");
endmodule : boot_loader_props
bind serial_eeprom_boot_loader boot_loader_props u_boot_loader_props (.clk, .rst, .mode_strap, .init_done, .cs_n,
   .cs_oe, .sclk, .sclk_oe, .sdo, .cmd_valid, .cmd_opcode, .cmd_data, .cmd_has_data, .modes_write, .mask_write,
   .low_supply_detect_mask_bit, .conv_start, .busy, .done);

// File: eeprom_model.sv
// Serial memory partner that answers read transfers
`timescale 1ns/1ns
module eeprom_model (
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic sdo,
   output logic sdi,
   output logic [15:0] rx_hdr
);
   // ****
   // Stored boot stream
   // ****
   localparam logic [7:0] IMG [13] = '{8'h60, 8'h00, 8'h01, 8'he0, 8'h74, 8'h00, 8'h00, 8'h04, 8'he8, 8'h78, 8'h00,
      8'h01, 8'h00};
   int cnt = 0;
   logic bit_r = 1'b0;
   initial rx_hdr = 16'h0000;
   always @(negedge cs_n) cnt = 0;
   always @(posedge sclk) begin
      if (cnt < 16) rx_hdr = {rx_hdr[14:0], sdo};
      cnt++;
   end
   always @(negedge sclk) begin
      if (!cs_n && cnt >= 16) bit_r = (cnt < 120) ? IMG[(cnt - 16) / 8][7 - (cnt - 16) % 8] : 1'b1;
   end
   // No pull-up here, so a released line shows the inverse of the last bit
   assign sdi = cs_n ? !bit_r : bit_r;
endmodule : eeprom_model

// File: serial_eeprom_boot_loader_test.sv
// Testbench for the serial memory boot loader
`timescale 1ns/1ns
module serial_eeprom_boot_loader_test;
   logic clk = 0, rst = 1, mode_strap = 0, init_done = 0;
   logic sdi, cs_n, cs_oe, sclk, sclk_oe, sdo, cmd_valid, cmd_has_data, modes_write, mask_write, conv_start;
   logic low_supply_detect_mask_bit, busy, done;
   logic [7:0] cmd_opcode;
   logic [23:0] cmd_data;
   logic [15:0] rx_hdr;
   logic [7:0] ops [4] = '{8'h60, 8'h74, 8'he8, 8'h78};
   logic [23:0] dat [4] = '{24'h0001e0, 24'h000004, 24'h000000, 24'h000100};
   int n_errors = 0, n_checks = 0, k;
   serial_eeprom_boot_loader u_serial_eeprom_boot_loader (.clk, .rst, .mode_strap, .init_done, .sdi, .cs_n, .cs_oe,
      .sclk, .sclk_oe, .sdo, .cmd_valid, .cmd_opcode, .cmd_data, .cmd_has_data, .modes_write, .mask_write,
      .low_supply_detect_mask_bit, .conv_start, .busy, .done);
   eeprom_model u_eeprom_model (.cs_n, .sclk, .sdo, .sdi, .rx_hdr);
   // ****
   // Tasks and sequence
   // ****
   initial forever #50 clk = ~clk;
   task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: %s", $time, what);
      end
   endtask : chk
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : tally_and_finish
   initial begin
      repeat (12) @(negedge clk);
      rst = 0;
      repeat (20) @(negedge clk);
      chk({done, cs_oe, sclk_oe, cs_n}, 4'h9, "strap low must stay host side");
      $display("test strap_low ended");
      rst = 1;
      mode_strap = 1;
      repeat (2) @(negedge clk);
      rst = 0;
      repeat (60) @(negedge clk);
      chk({cs_n, busy, cs_oe, sclk_oe}, 4'hb, "fetch before init");
      init_done = 1;
      for (int i = 0; i < 4; i++) begin
         k = 0;
         do begin
            @(posedge clk);
            #1;
            k++;
         end while (cmd_valid !== 1'b1 && k < 3000);
         chk(k < 3000, 1'b1, "entry never arrived");
         chk(cmd_has_data, ops[i] != 8'he8, "entry length");
         chk(cmd_opcode, ops[i], "entry opcode");
         chk(cmd_data, dat[i], "entry data");
         chk({modes_write, mask_write, conv_start}, {ops[i] == 8'h60, ops[i] == 8'h74, ops[i] == 8'he8}, "pulses");
      end
      chk(rx_hdr, 16'h0300, "read opcode and address");
      repeat (5) @(posedge clk);
      #1;
      chk({cs_n, busy, done, low_supply_detect_mask_bit}, 4'hb, "stop and mask state");
      $display("test memory_boot ended");
      tally_and_finish();
   end
   // Four entries take about 2500 cycles, so this leaves ample margin
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      $display("wrong value at %0t: watchdog expired", $time);
      tally_and_finish();
   end
endmodule : serial_eeprom_boot_loader_test
